// ==== ppf_pkg.sv ====
package ppf_pkg;
    localparam int CLK_PERIOD_NS = 20;
    localparam int PULSE_MIN_NS = 250;
    localparam int PULSE_MIN_CYC = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Action bit codes
    localparam logic [1:0] ACT_ADDR = 2'h0;
    localparam logic [1:0] ACT_DATA = 2'h1;
    localparam logic [1:0] ACT_CMD = 2'h2;
    localparam logic [1:0] ACT_IDLE = 2'h3;
    // Command codes
    localparam logic [7:0] CMD_ERASE = 8'h80;
    localparam logic [7:0] CMD_WR_FUSE = 8'h40;
    localparam logic [7:0] CMD_WR_LOCK = 8'h20;
    localparam logic [7:0] CMD_WR_FLASH = 8'h10;
    localparam logic [7:0] CMD_WR_NVDATA = 8'h11;
    localparam logic [7:0] CMD_RD_IDENT = 8'h08;
    localparam logic [7:0] CMD_RD_FUSE = 8'h04;
    localparam logic [7:0] CMD_RD_FLASH = 8'h02;
    localparam logic [7:0] CMD_RD_NVDATA = 8'h03;
    localparam logic [7:0] CMD_NOP = 8'h00;
    // Fuse reset values
    localparam logic [7:0] EXT_FUSE_RST = 8'hFD;
    localparam logic [7:0] HIGH_FUSE_RST = 8'h99;
    localparam logic [7:0] LOW_FUSE_RST = 8'hE1;
    localparam logic [7:0] LOCK_RST = 8'hFF;
    localparam logic [7:0] EXT_UNUSED_ONES = 8'hFC;
    localparam logic [7:0] LOCK_UNUSED_ONES = 8'hC0;
    // Field positions
    localparam int EXT_LEGACY_COMPAT_MODE = 1;
    localparam int EXT_WATCHDOG_FORCED_ON = 0;
    localparam int HI_ONCHIP_DEBUG_ENABLE = 7;
    localparam int HI_SCAN_PORT_ENABLE = 6;
    localparam int HI_SERIAL_PROG_ENABLE = 5;
    localparam int HI_OSCILLATOR_OPTION = 4;
    localparam int HI_KEEP_NVDATA_ON_ERASE = 3;
    localparam int HI_BOOT_SIZE_SELECT_MSB = 2;
    localparam int HI_BOOT_SIZE_SELECT_LSB = 1;
    localparam int HI_RESET_VECTOR_SELECT = 0;
    localparam int LO_BROWNOUT_TRIP_LEVEL = 7;
    localparam int LO_BROWNOUT_DETECTOR_ON = 6;
    localparam int LO_STARTUP_TIME_MSB = 5;
    localparam int LO_STARTUP_TIME_LSB = 4;
    localparam int LO_CLOCK_SOURCE_MSB = 3;
    localparam int LO_CLOCK_SOURCE_LSB = 0;
    localparam int LOCK_MEMORY_LOCK_FIRST = 0;
    // Page geometry
    localparam int FLASH_WORD_MSB = 6;
    localparam int FLASH_PAGE_LSB = 7;
    localparam int FLASH_PAGE_MSB = 14;
    localparam int NVDATA_BYTE_MSB = 2;
    localparam int NVDATA_PAGE_LSB = 3;
    localparam int NVDATA_PAGE_MSB = 10;
    // Identification row
    localparam logic [7:0] IDENT_LAST_ADDR = 8'h02;
    localparam logic [7:0] CAL_LAST_ADDR = 8'h03;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    typedef enum logic [1:0] {
        PPF_IDLE = 2'h1,
        PPF_BUSY = 2'h2
    } ppf_state_e;
endpackage

// ==== ppf_pin_if.sv ====
`timescale 1ns/1ps
interface ppf_pin_if;
    logic load_pulse;
    logic write_pulse;
    logic page_latch_pulse;
    logic prog_enter;
    logic prog_leave;
    logic prog_level;
    logic spi_level;
    logic oe_active;
    logic [1:0] action;
    logic byte_sel_first;
    logic byte_sel_second;
    logic [7:0] data;
    modport front (
        output load_pulse, write_pulse, page_latch_pulse, prog_enter, prog_leave,
        output prog_level, spi_level, oe_active, action, byte_sel_first,
        output byte_sel_second, data
    );
    modport core (
        input load_pulse, write_pulse, page_latch_pulse, prog_enter, prog_leave,
        input prog_level, spi_level, oe_active, action, byte_sel_first,
        input byte_sel_second, data
    );
endinterface

// ==== ppf_pin_front.sv ====
`timescale 1ns/1ps
module ppf_pin_front import ppf_pkg::*; (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // Programming pins
    input wire logic load_strobe_in,
    input wire logic load_action_lo_in,
    input wire logic load_action_hi_in,
    input wire logic byte_sel_first_in,
    input wire logic byte_sel_second_in,
    input wire logic page_buffer_latch_in,
    input wire logic write_n_in,
    input wire logic output_enable_n_in,
    input wire logic prog_mode_in,
    input wire logic spi_prog_mode_in,
    input wire logic [7:0] data_in,
    // Events to the core
    ppf_pin_if.front pins
);
    localparam int W = 18;
    logic [W-1:0] raw;
    logic [W-1:0] sync1_ff;
    logic [W-1:0] sync2_ff;
    logic [3:0] prev_ff;
    logic [3:0] nxt_prev;

    assign raw = {data_in, spi_prog_mode_in, prog_mode_in, output_enable_n_in, write_n_in,
                  page_buffer_latch_in, byte_sel_second_in, byte_sel_first_in,
                  load_action_hi_in, load_action_lo_in, load_strobe_in};

    always_comb begin
        nxt_prev = {sync2_ff[8], sync2_ff[6], sync2_ff[5], sync2_ff[0]};
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            prev_ff <= 4'h0;
        end else begin
            sync1_ff <= raw;
            sync2_ff <= sync1_ff;
            prev_ff <= nxt_prev;
        end
    end

    assign pins.load_pulse = sync2_ff[0] && !prev_ff[0];
    assign pins.page_latch_pulse = sync2_ff[5] && !prev_ff[1];
    assign pins.write_pulse = !sync2_ff[6] && prev_ff[2];
    assign pins.prog_enter = sync2_ff[8] && !prev_ff[3];
    assign pins.prog_leave = !sync2_ff[8] && prev_ff[3];
    assign pins.prog_level = sync2_ff[8];
    assign pins.spi_level = sync2_ff[9];
    assign pins.oe_active = !sync2_ff[7];
    assign pins.action = {sync2_ff[2], sync2_ff[1]};
    assign pins.byte_sel_first = sync2_ff[3];
    assign pins.byte_sel_second = sync2_ff[4];
    assign pins.data = sync2_ff[17:10];
endmodule // ppf_pin_front

// ==== ppf_fuse_port.sv ====
`timescale 1ns/1ps
module ppf_fuse_port import ppf_pkg::*; #(
    parameter int BUSY_CYCLES = 16,
    parameter int ERASE_CYCLES = 64,
    parameter logic [7:0] IDENT_BYTE0 = 8'hA5, // arbitrary value
    parameter logic [7:0] IDENT_BYTE1 = 8'h5A, // arbitrary value
    parameter logic [7:0] IDENT_BYTE2 = 8'h3C, // arbitrary value
    parameter logic [7:0] CAL_1MHZ = 8'h80,
    parameter logic [7:0] CAL_2MHZ = 8'h80,
    parameter logic [7:0] CAL_4MHZ = 8'h80,
    parameter logic [7:0] CAL_8MHZ = 8'h80
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // Programming pins
    input wire logic load_strobe_in,
    input wire logic load_action_lo_in,
    input wire logic load_action_hi_in,
    input wire logic byte_sel_first_in,
    input wire logic byte_sel_second_in,
    input wire logic page_buffer_latch_in,
    input wire logic write_n_in,
    input wire logic output_enable_n_in,
    input wire logic prog_mode_in,
    input wire logic spi_prog_mode_in,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe_out,
    output logic ready_busy_out,
    // Software calibration load
    input wire logic cal_load_in,
    input wire logic [7:0] cal_value_in,
    output logic [7:0] osc_calibration_reg_out,
    // Latched configuration
    output logic [7:0] extended_config_fuses_out,
    output logic [7:0] high_config_fuses_out,
    output logic [7:0] low_config_fuses_out,
    // Page addressing and latch
    output logic [FLASH_WORD_MSB:0] flash_word_index_out,
    output logic [FLASH_PAGE_MSB-FLASH_PAGE_LSB:0] flash_page_index_out,
    output logic [NVDATA_PAGE_MSB:0] nvdata_addr_out,
    output logic [15:0] page_word_out,
    output logic page_word_strobe_out
);
    if (BUSY_CYCLES < 2 || ERASE_CYCLES < 2 ||
        BUSY_CYCLES > 1000 || ERASE_CYCLES > 1000) begin : g_bad_cycles
        $error("busy cycle counts must lie in 2..1000");
    end

    ppf_pin_if pins();

    ppf_pin_front u_front (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .load_strobe_in(load_strobe_in),
        .load_action_lo_in(load_action_lo_in),
        .load_action_hi_in(load_action_hi_in),
        .byte_sel_first_in(byte_sel_first_in),
        .byte_sel_second_in(byte_sel_second_in),
        .page_buffer_latch_in(page_buffer_latch_in),
        .write_n_in(write_n_in),
        .output_enable_n_in(output_enable_n_in),
        .prog_mode_in(prog_mode_in),
        .spi_prog_mode_in(spi_prog_mode_in),
        .data_in(data_in),
        .pins(pins)
    );

    function automatic logic is_write_cmd(input logic [7:0] c);
        return c == CMD_ERASE || c == CMD_WR_FUSE || c == CMD_WR_LOCK ||
               c == CMD_WR_FLASH || c == CMD_WR_NVDATA;
    endfunction

    ppf_state_e state_ff, nxt_state;
    logic [15:0] busy_cnt_ff, nxt_busy_cnt;
    logic [7:0] cmd_ff, nxt_cmd;
    logic [15:0] addr_ff, nxt_addr;
    logic [15:0] word_ff, nxt_word;
    logic [7:0] ext_nv_ff, nxt_ext_nv;
    logic [7:0] high_nv_ff, nxt_high_nv;
    logic [7:0] low_nv_ff, nxt_low_nv;
    logic [7:0] lock_nv_ff, nxt_lock_nv;
    logic [7:0] ext_lat_ff, nxt_ext_lat;
    logic [7:0] high_lat_ff, nxt_high_lat;
    logic [7:0] low_lat_ff, nxt_low_lat;
    logic [7:0] cal_reg_ff, nxt_cal_reg;
    logic [7:0] dout_ff, nxt_dout;
    logic doe_ff, nxt_doe;
    logic strobe_ff, nxt_strobe;
    logic boot_ff, nxt_boot;
    logic start;
    logic fuse_ok;
    logic [7:0] rd_val;

    assign start = pins.write_pulse && pins.prog_level && state_ff == PPF_IDLE &&
                   is_write_cmd(cmd_ff);
    assign fuse_ok = lock_nv_ff[LOCK_MEMORY_LOCK_FIRST];

    // Read data selection
    always_comb begin
        rd_val = ERASED_BYTE;
        case (cmd_ff)
            CMD_RD_IDENT: begin
                if (pins.byte_sel_first) begin
                    case (addr_ff[7:0])
                        8'h00: rd_val = CAL_1MHZ;
                        8'h01: rd_val = CAL_2MHZ;
                        8'h02: rd_val = CAL_4MHZ;
                        CAL_LAST_ADDR: rd_val = CAL_8MHZ;
                        default: rd_val = ERASED_BYTE;
                    endcase
                end else begin
                    case (addr_ff[7:0])
                        8'h00: rd_val = IDENT_BYTE0;
                        8'h01: rd_val = IDENT_BYTE1;
                        IDENT_LAST_ADDR: rd_val = IDENT_BYTE2;
                        default: rd_val = ERASED_BYTE;
                    endcase
                end
            end
            CMD_RD_FUSE: begin
                case ({pins.byte_sel_second, pins.byte_sel_first})
                    2'h0: rd_val = low_nv_ff;
                    2'h1: rd_val = lock_nv_ff;
                    2'h2: rd_val = ext_nv_ff;
                    default: rd_val = high_nv_ff;
                endcase
            end
            default: rd_val = ERASED_BYTE;
        endcase
    end

    // Next-state logic
    always_comb begin
        nxt_state = state_ff;
        nxt_busy_cnt = busy_cnt_ff;
        nxt_cmd = cmd_ff;
        nxt_addr = addr_ff;
        nxt_word = word_ff;
        nxt_ext_nv = ext_nv_ff;
        nxt_high_nv = high_nv_ff;
        nxt_low_nv = low_nv_ff;
        nxt_lock_nv = lock_nv_ff;
        nxt_ext_lat = ext_lat_ff;
        nxt_high_lat = high_lat_ff;
        nxt_low_lat = low_lat_ff;
        nxt_cal_reg = cal_load_in ? cal_value_in : cal_reg_ff;
        nxt_doe = pins.oe_active && pins.prog_level;
        nxt_dout = rd_val;
        nxt_strobe = 1'b0;
        nxt_boot = 1'b0;
        if (pins.load_pulse && pins.prog_level && state_ff == PPF_IDLE) begin
            case (pins.action)
                ACT_ADDR: begin
                    if (pins.byte_sel_first)
                        nxt_addr[15:8] = pins.data;
                    else
                        nxt_addr[7:0] = pins.data;
                end
                ACT_DATA: begin
                    if (pins.byte_sel_first)
                        nxt_word[15:8] = pins.data;
                    else
                        nxt_word[7:0] = pins.data;
                end
                ACT_CMD: nxt_cmd = pins.data;
                default: nxt_cmd = cmd_ff;
            endcase
        end
        if (pins.page_latch_pulse && pins.prog_level && state_ff == PPF_IDLE)
            nxt_strobe = 1'b1;
        case (state_ff)
            PPF_IDLE: begin
                if (start) begin
                    nxt_state = PPF_BUSY;
                    nxt_busy_cnt = (cmd_ff == CMD_ERASE) ? 16'(ERASE_CYCLES - 1) :
                                   16'(BUSY_CYCLES - 1);
                    if (cmd_ff == CMD_ERASE)
                        nxt_lock_nv = LOCK_RST;
                    if (cmd_ff == CMD_WR_LOCK)
                        nxt_lock_nv = lock_nv_ff & pins.data | LOCK_UNUSED_ONES;
                    if (cmd_ff == CMD_WR_FUSE && fuse_ok) begin
                        case ({pins.byte_sel_second, pins.byte_sel_first})
                            2'h0: nxt_low_nv = pins.data;
                            2'h1: begin
                                nxt_high_nv = pins.data;
                                if (pins.spi_level)
                                    nxt_high_nv[HI_SERIAL_PROG_ENABLE] =
                                        high_nv_ff[HI_SERIAL_PROG_ENABLE];
                                nxt_high_lat[HI_KEEP_NVDATA_ON_ERASE] =
                                    pins.data[HI_KEEP_NVDATA_ON_ERASE];
                            end
                            2'h2: nxt_ext_nv = pins.data | EXT_UNUSED_ONES;
                            default: nxt_low_nv = low_nv_ff;
                        endcase
                    end
                end
            end
            PPF_BUSY: begin
                if (busy_cnt_ff == 16'h0000)
                    nxt_state = PPF_IDLE;
                else
                    nxt_busy_cnt = busy_cnt_ff - 16'h0001;
            end
            default: nxt_state = PPF_IDLE;
        endcase
        if (pins.prog_enter || pins.prog_leave || boot_ff) begin
            nxt_ext_lat = ext_nv_ff;
            nxt_high_lat = high_nv_ff;
            nxt_low_lat = low_nv_ff;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            state_ff <= PPF_IDLE;
            busy_cnt_ff <= 16'h0000;
            cmd_ff <= CMD_NOP;
            addr_ff <= 16'h0000;
            word_ff <= 16'h0000;
            ext_nv_ff <= EXT_FUSE_RST;
            high_nv_ff <= HIGH_FUSE_RST;
            low_nv_ff <= LOW_FUSE_RST;
            lock_nv_ff <= LOCK_RST;
            ext_lat_ff <= EXT_FUSE_RST;
            high_lat_ff <= HIGH_FUSE_RST;
            low_lat_ff <= LOW_FUSE_RST;
            cal_reg_ff <= CAL_1MHZ;
            dout_ff <= 8'h00;
            doe_ff <= 1'b0;
            strobe_ff <= 1'b0;
            boot_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            busy_cnt_ff <= nxt_busy_cnt;
            cmd_ff <= nxt_cmd;
            addr_ff <= nxt_addr;
            word_ff <= nxt_word;
            ext_nv_ff <= nxt_ext_nv;
            high_nv_ff <= nxt_high_nv;
            low_nv_ff <= nxt_low_nv;
            lock_nv_ff <= nxt_lock_nv;
            ext_lat_ff <= nxt_ext_lat;
            high_lat_ff <= nxt_high_lat;
            low_lat_ff <= nxt_low_lat;
            cal_reg_ff <= nxt_cal_reg;
            dout_ff <= nxt_dout;
            doe_ff <= nxt_doe;
            strobe_ff <= nxt_strobe;
            boot_ff <= nxt_boot;
        end
    end

    assign data_out = dout_ff;
    assign data_oe_out = doe_ff;
    assign ready_busy_out = state_ff == PPF_IDLE;
    assign osc_calibration_reg_out = cal_reg_ff;
    assign extended_config_fuses_out = ext_lat_ff;
    assign high_config_fuses_out = high_lat_ff;
    assign low_config_fuses_out = low_lat_ff;
    assign flash_word_index_out = addr_ff[FLASH_WORD_MSB:0];
    assign flash_page_index_out = addr_ff[FLASH_PAGE_MSB:FLASH_PAGE_LSB];
    assign nvdata_addr_out = addr_ff[NVDATA_PAGE_MSB:0];
    assign page_word_out = word_ff;
    assign page_word_strobe_out = strobe_ff;

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    property p_start_busy;
        start |=> !ready_busy_out ##1 !ready_busy_out;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("busy not shown");

    property p_busy_ends;
        $fell(ready_busy_out) |-> ##[1:1000] ready_busy_out;
    endproperty
    a_busy_ends: assert property (p_busy_ends) else $error("busy never ends");

    property p_erase_keeps;
        start && cmd_ff == CMD_ERASE |=> $stable(low_nv_ff) && $stable(high_nv_ff)
            && $stable(ext_nv_ff) && lock_nv_ff == LOCK_RST;
    endproperty
    a_erase_keeps: assert property (p_erase_keeps) else $error("erase hit fuses");

    property p_lock_refuse;
        start && cmd_ff == CMD_WR_FUSE && !lock_nv_ff[0] |=> $stable(low_nv_ff)
            && $stable(high_nv_ff) && $stable(ext_nv_ff);
    endproperty
    a_lock_refuse: assert property (p_lock_refuse) else $error("locked fuse written");

    property p_spi_keep;
        start && cmd_ff == CMD_WR_FUSE && pins.spi_level |=> $stable(high_nv_ff[5]);
    endproperty
    a_spi_keep: assert property (p_spi_keep) else $error("serial fuse changed");

    property p_ext_ones;
        ext_nv_ff[7:2] == 6'h3F;
    endproperty
    a_ext_ones: assert property (p_ext_ones) else $error("unused bits not 1");

    property p_fuse_value;
        start && cmd_ff == CMD_WR_FUSE && lock_nv_ff[0] && !pins.byte_sel_second
            && !pins.byte_sel_first |=> low_nv_ff == $past(pins.data);
    endproperty
    a_fuse_value: assert property (p_fuse_value) else $error("fuse value wrong");

    property p_keep_now;
        start && cmd_ff == CMD_WR_FUSE && lock_nv_ff[0] && pins.byte_sel_first
            && !pins.byte_sel_second |=> high_lat_ff[3] == high_nv_ff[3];
    endproperty
    a_keep_now: assert property (p_keep_now) else $error("preserve fuse late");

    property p_latch_hold;
        pins.prog_level && !pins.prog_enter && !pins.prog_leave && !boot_ff
            |=> $stable(low_lat_ff);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latched fuse moved");

    property p_oe_drive;
        data_oe_out |-> $past(pins.oe_active) && $past(pins.prog_level);
    endproperty
    a_oe_drive: assert property (p_oe_drive) else $error("bus driven wrongly");

    c_erase: cover property (start && cmd_ff == CMD_ERASE);
    c_fuse: cover property (start && cmd_ff == CMD_WR_FUSE && fuse_ok);
    c_ident: cover property (data_oe_out && cmd_ff == CMD_RD_IDENT);
    c_enter: cover property (pins.prog_enter);
endmodule // ppf_fuse_port

// ==== ppf_prog_model.sv ====
`timescale 1ns/1ps
module ppf_prog_model import ppf_pkg::*; (
    // Clock and readback
    input wire logic clk_sys_in,
    input wire logic [7:0] rd_data_in,
    input wire logic rd_oe_in,
    // Programming pins
    output logic strobe_out,
    output logic act_lo_out,
    output logic act_hi_out,
    output logic sel_first_out,
    output logic sel_second_out,
    output logic latch_out,
    output logic wr_n_out,
    output logic oe_n_out,
    output logic [7:0] data_out
);
    initial begin
        {latch_out, act_hi_out, act_lo_out, sel_first_out} = 4'h0;
        {strobe_out, sel_second_out} = 2'h0;
        {wr_n_out, oe_n_out} = 2'h3;
        data_out = 8'h00;
    end
    task automatic hold();
        repeat (PULSE_MIN_CYC + 1) @(posedge clk_sys_in);
    endtask
    task automatic load(input logic [1:0] act, input logic sel, input logic [7:0] val);
        {act_hi_out, act_lo_out} <= act;
        sel_first_out <= sel;
        data_out <= val;
        hold();
        strobe_out <= 1'b1;
        hold();
        strobe_out <= 1'b0;
        hold();
    endtask
    task automatic write(input logic [1:0] sel);
        {sel_second_out, sel_first_out} <= sel;
        hold();
        wr_n_out <= 1'b0;
        hold();
        wr_n_out <= 1'b1;
        @(posedge clk_sys_in);
    endtask
    task automatic read(input logic [1:0] sel, output logic [7:0] val, output logic oe);
        {sel_second_out, sel_first_out} <= sel;
        data_out <= ~data_out;
        oe_n_out <= 1'b0;
        hold();
        val = rd_data_in;
        oe = rd_oe_in;
        oe_n_out <= 1'b1;
        hold();
    endtask
    task automatic latch();
        latch_out <= 1'b1;
        hold();
        latch_out <= 1'b0;
        hold();
    endtask
endmodule // ppf_prog_model

// ==== tb_parallel_prog_fuse_port.sv ====
`timescale 1ns/1ps
module tb_parallel_prog_fuse_port import ppf_pkg::*;;
    localparam logic [7:0] ID [3] = '{8'h6B, 8'h2D, 8'hC7}; // Arbitrary values
    localparam logic [7:0] CAL [4] = '{8'h41, 8'h52, 8'h64, 8'h78};
    logic clk_sys_in, rst_in, load_strobe_in, load_action_lo_in, load_action_hi_in;
    logic byte_sel_first_in, byte_sel_second_in, page_buffer_latch_in, write_n_in;
    logic output_enable_n_in, prog_mode_in, spi_prog_mode_in, cal_load_in;
    logic data_oe_out, ready_busy_out, page_word_strobe_out;
    logic [7:0] data_in, data_out, cal_value_in, osc_calibration_reg_out;
    logic [7:0] extended_config_fuses_out, high_config_fuses_out, low_config_fuses_out;
    logic [6:0] flash_word_index_out;
    logic [7:0] flash_page_index_out;
    logic [10:0] nvdata_addr_out;
    logic [15:0] page_word_out;
    int error_cnt = 0;
    int tests_run = 0;
    int n_strobe = 0;
    ppf_fuse_port #(.BUSY_CYCLES(40), .ERASE_CYCLES(60), .IDENT_BYTE0(ID[0]),
        .IDENT_BYTE1(ID[1]), .IDENT_BYTE2(ID[2]), .CAL_1MHZ(CAL[0]), .CAL_2MHZ(CAL[1]),
        .CAL_4MHZ(CAL[2]), .CAL_8MHZ(CAL[3])) i_dut (.clk_sys_in, .rst_in, .load_strobe_in,
        .load_action_lo_in, .load_action_hi_in, .byte_sel_first_in, .byte_sel_second_in,
        .page_buffer_latch_in, .write_n_in, .output_enable_n_in, .prog_mode_in,
        .spi_prog_mode_in, .data_in, .data_out, .data_oe_out, .ready_busy_out, .cal_load_in,
        .cal_value_in, .osc_calibration_reg_out, .extended_config_fuses_out,
        .high_config_fuses_out, .low_config_fuses_out, .flash_word_index_out,
        .flash_page_index_out, .nvdata_addr_out, .page_word_out, .page_word_strobe_out);
    ppf_prog_model m (.clk_sys_in, .rd_data_in(data_out), .rd_oe_in(data_oe_out),
        .strobe_out(load_strobe_in), .act_lo_out(load_action_lo_in),
        .act_hi_out(load_action_hi_in), .sel_first_out(byte_sel_first_in),
        .sel_second_out(byte_sel_second_in), .latch_out(page_buffer_latch_in),
        .wr_n_out(write_n_in), .oe_n_out(output_enable_n_in), .data_out(data_in));
    initial begin
        clk_sys_in = 1'b0;
        forever #(CLK_PERIOD_NS / 2) clk_sys_in = ~clk_sys_in;
    end
    always @(posedge clk_sys_in) if (page_word_strobe_out === 1'b1) n_strobe++;
    function automatic logic [7:0] hi_exp(input logic [7:0] old, input logic [7:0] d);
        hi_exp = d;
        hi_exp[HI_SERIAL_PROG_ENABLE] = old[HI_SERIAL_PROG_ENABLE];
    endfunction
    task automatic finish_test();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic wait_ready();
        int n = 0;
        while (ready_busy_out !== 1'b1 && n < 400) begin
            @(posedge clk_sys_in);
            n++;
        end
        if (ready_busy_out !== 1'b1) begin
            error_cnt++;
            finish_test();
        end
    endtask
    task automatic rd(input logic [1:0] sel, input logic [7:0] exp);
        logic [7:0] v;
        logic oe;
        m.read(sel, v, oe);
        check(v, exp, "read data");
        check(oe, 1'b1, "bus driven");
        check(data_oe_out, 1'b0, "bus released");
    endtask
    task automatic fuse_wr(input logic [1:0] sel, input logic [7:0] d);
        m.load(ACT_CMD, 1'b0, CMD_WR_FUSE);
        m.load(ACT_DATA, 1'b0, d);
        m.write(sel);
        check(ready_busy_out, 1'b0, "busy");
        wait_ready();
    endtask
    initial begin
        logic [7:0] v, h, e, hx, a0, a1, d0, d1;
        int ns;
        rst_in = 1'b1;
        prog_mode_in = 1'b0;
        spi_prog_mode_in = 1'b0;
        cal_load_in = 1'b0;
        cal_value_in = 8'h00;
        v = 8'($urandom(32'h37E7));
        repeat (4) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        repeat (3) @(posedge clk_sys_in);
        check(extended_config_fuses_out, EXT_FUSE_RST, "ext reset");
        check(high_config_fuses_out, HIGH_FUSE_RST, "high reset");
        check(low_config_fuses_out, LOW_FUSE_RST, "low reset");
        check(osc_calibration_reg_out, CAL[0], "cal reset");
        check(ready_busy_out, 1'b1, "ready");
        cal_value_in <= v;
        cal_load_in <= 1'b1;
        @(posedge clk_sys_in);
        cal_load_in <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
        check(osc_calibration_reg_out, v, "cal load");
        prog_mode_in <= 1'b1;
        repeat (6) @(posedge clk_sys_in);
        m.load(ACT_CMD, 1'b0, CMD_RD_FUSE);
        rd(2'h0, LOW_FUSE_RST);
        rd(2'h3, HIGH_FUSE_RST);
        rd(2'h2, EXT_FUSE_RST);
        rd(2'h1, LOCK_RST);
        m.load(ACT_CMD, 1'b0, CMD_RD_IDENT);
        for (int i = 0; i < 4; i++) begin
            m.load(ACT_ADDR, 1'b0, 8'(i));
            if (i < 3) rd(2'h0, ID[i]);
            rd(2'h1, CAL[i]);
        end
        fuse_wr(2'h0, v);
        h = 8'($urandom);
        spi_prog_mode_in <= 1'b1;
        fuse_wr(2'h1, h);
        spi_prog_mode_in <= 1'b0;
        hx = HIGH_FUSE_RST;
        hx[HI_KEEP_NVDATA_ON_ERASE] = h[HI_KEEP_NVDATA_ON_ERASE];
        check(high_config_fuses_out, hx, "keep early");
        e = 8'($urandom);
        fuse_wr(2'h2, e);
        check(low_config_fuses_out, LOW_FUSE_RST, "low held");
        m.load(ACT_CMD, 1'b0, CMD_RD_FUSE);
        rd(2'h0, v);
        rd(2'h3, hi_exp(HIGH_FUSE_RST, h));
        rd(2'h2, e | EXT_UNUSED_ONES);
        check(low_config_fuses_out, LOW_FUSE_RST, "low still held");
        prog_mode_in <= 1'b0;
        repeat (8) @(posedge clk_sys_in);
        check(low_config_fuses_out, v, "low latched");
        check(high_config_fuses_out, hi_exp(HIGH_FUSE_RST, h), "high latched");
        check(extended_config_fuses_out, e | EXT_UNUSED_ONES, "ext latched");
        prog_mode_in <= 1'b1;
        repeat (6) @(posedge clk_sys_in);
        m.load(ACT_CMD, 1'b0, CMD_WR_LOCK);
        m.load(ACT_DATA, 1'b0, 8'hFE);
        m.write(2'h0);
        wait_ready();
        fuse_wr(2'h0, ~v);
        m.load(ACT_CMD, 1'b0, CMD_ERASE);
        m.write(2'h0);
        wait_ready();
        m.load(ACT_CMD, 1'b0, CMD_RD_FUSE);
        rd(2'h0, v);
        rd(2'h1, LOCK_RST);
        a0 = 8'($urandom);
        a1 = 8'($urandom);
        d0 = 8'($urandom);
        d1 = 8'($urandom);
        m.load(ACT_CMD, 1'b0, CMD_WR_FLASH);
        m.load(ACT_ADDR, 1'b0, a0);
        m.load(ACT_ADDR, 1'b1, a1);
        m.load(ACT_IDLE, 1'b0, ~a0);
        check(flash_word_index_out, a0[6:0], "word");
        check(flash_page_index_out, {a1[6:0], a0[7]}, "page");
        check(nvdata_addr_out, {a1[2:0], a0}, "nvdata");
        m.load(ACT_DATA, 1'b0, d0);
        m.load(ACT_DATA, 1'b1, d1);
        ns = n_strobe;
        m.latch();
        check(page_word_out, {d1, d0}, "data word");
        check(16'(n_strobe - ns), 16'h0001, "latch pulse");
        m.write(2'h0);
        check(ready_busy_out, 1'b0, "flash busy");
        wait_ready();
        m.load(ACT_CMD, 1'b0, CMD_RD_FLASH);
        rd(2'h0, ERASED_BYTE);
        m.load(ACT_CMD, 1'b0, CMD_RD_NVDATA);
        rd(2'h0, ERASED_BYTE);
        m.load(ACT_CMD, 1'b0, CMD_WR_NVDATA);
        m.write(2'h0);
        check(ready_busy_out, 1'b0, "nvdata busy");
        wait_ready();
        finish_test();
    end
endmodule // tb_parallel_prog_fuse_port
